// ===== rtl/haptic_consts.svh
// Offsets, fields, reset values and timing counts of the haptic mode link
// Assumes inclusion by bare name from the device, host and testbench files
`ifndef HAPTIC_CONSTS_SVH
`define HAPTIC_CONSTS_SVH

// Device register offsets
`define DEV_STATUS 8'h00
`define DEV_MODE 8'h01
`define DEV_SAMPLE 8'h02
`define DEV_LAUNCH 8'h0C
`define DEV_CTRL3 8'h1D

// Mode, status and CTRL3 register fields and mode reset values
`define MODE_SRST_BIT 7
`define MODE_STBY_BIT 6
`define MODE_STBY_RST 1'b1
`define MODE_SEL_RST 3'h0
`define STATUS_OUTCOME_BIT 3
`define CTRL3_SRC_BIT 1
`define CTRL3_FMT_BIT 3
`define CTRL3_AC_BIT 5

// Mode select codes
`define M_INTERNAL 3'h0
`define M_EDGE 3'h1
`define M_LEVEL 3'h2
`define M_PWM_ANALOG 3'h3
`define M_AUDIO 3'h4
`define M_REALTIME 3'h5
`define M_DIAG 3'h6
`define M_CAL 3'h7

// Drive level and sign flip mask
`define PLAY_LEVEL 8'hC0
`define SIGN_FLIP 8'h80

// Timing
`define CLK_PERIOD_NS 50
`define PLAY_TIME_NS 100000
`define PLAY_CYCLES (`PLAY_TIME_NS / `CLK_PERIOD_NS)
`define CHECK_TIME_NS 150000
`define CHECK_CYCLES (`CHECK_TIME_NS / `CLK_PERIOD_NS)

// Controller registers on the software bus
`define H_CMD 32'h0000_0000
`define H_STATUS 32'h0000_0004
`define H_IRQ_STATUS 32'h0000_0008
`define H_IRQ_ENABLE 32'h0000_000C
`define H_IRQ_CLEAR 32'h0000_0010
`define H_CMD_WRITE_BIT 16
`define IRQ_DONE_BIT 0
`define IRQ_REFUSED_BIT 1
`define IRQ_W 2
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3

`endif

// ===== rtl/haptic_pkg.sv
// Types shared by both ends of the haptic mode link
// Assumes the constants header is included where offsets are needed
package haptic_pkg;
  typedef enum logic {LINK_IDLE, LINK_WAIT} link_state_e;
  typedef logic [7:0] byte_t;
endpackage

// ===== rtl/haptic_link.sv
// Register link joining the controller to the haptic device
// Assumes both ends run on the same aclk
`timescale 1ns/1ps
interface haptic_link;
  logic req;
  logic we;
  haptic_pkg::byte_t addr;
  haptic_pkg::byte_t wdata;
  logic ack;
  haptic_pkg::byte_t rdata;
  modport device (input req, input we, input addr, input wdata, output ack, output rdata);
  modport host (output req, output we, output addr, output wdata, input ack, input rdata);
endinterface

// ===== rtl/haptic_mode_device.sv
// Haptic device end: mode control register bank and trigger handling
// Assumes a host that holds req until ack; pins arrive asynchronously
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps
`include "haptic_consts.svh"
module haptic_mode_device #(
  parameter int PLAY_CYCLES = `PLAY_CYCLES,
  parameter int CHECK_CYCLES = `CHECK_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  haptic_link.device link,
  input wire logic input_trigger_pin,
  input wire logic [7:0] analog_level,
  input wire logic actuator_fault,
  output logic [7:0] drive_level,
  output logic drive_active,
  output logic launch
);
  logic [2:0] trig_s;
  logic [2:0] fault_s;
  logic trig_lvl;
  logic fault_lvl;
  logic soft_reset_bit;
  logic standby;
  logic [2:0] mode;
  logic [7:0] realtime_sample_value;
  logic realtime_sign_format;
  logic input_source;
  logic ac_coupled_input;
  logic check_outcome_flag;
  logic [15:0] run_cnt;
  logic clr_regs;
  logic take;
  logic wr;
  logic rd;
  logic rise;
  logic fall;
  logic run_done;
  logic checking;
  logic [7:0] next_rdata;

  assign clr_regs = !aresetn || soft_reset_bit;
  assign take = link.req && !link.ack;
  assign wr = take && link.we;
  assign rd = take && !link.we;
  assign rise = trig_s[1] && trig_s[2] && !trig_lvl;
  assign fall = !trig_s[1] && !trig_s[2] && trig_lvl;
  assign checking = (mode == `M_DIAG) || (mode == `M_CAL);
  assign run_done = launch && (run_cnt == 16'(checking ? CHECK_CYCLES - 1 : PLAY_CYCLES - 1));

  // Pin synchronisers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trig_s <= 3'h0;
      fault_s <= 3'h0;
    end else begin
      trig_s <= {trig_s[1:0], input_trigger_pin};
      fault_s <= {fault_s[1:0], actuator_fault};
    end
  end

  // Agreed pin levels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trig_lvl <= 1'b0;
      fault_lvl <= 1'b0;
    end else begin
      if (trig_s[1] == trig_s[2]) begin
        trig_lvl <= trig_s[2];
      end
      if (fault_s[1] == fault_s[2]) begin
        fault_lvl <= fault_s[2];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (clr_regs) begin
      soft_reset_bit <= 1'b0;
    end else if (wr && link.addr == `DEV_MODE) begin
      soft_reset_bit <= link.wdata[`MODE_SRST_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (clr_regs) begin
      standby <= `MODE_STBY_RST;
      mode <= `MODE_SEL_RST;
    end else if (wr && link.addr == `DEV_MODE) begin
      standby <= link.wdata[`MODE_STBY_BIT];
      mode <= link.wdata[2:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (clr_regs) begin
      realtime_sample_value <= 8'h00;
      realtime_sign_format <= 1'b0;
      input_source <= 1'b0;
      ac_coupled_input <= 1'b0;
    end else if (wr && link.addr == `DEV_SAMPLE) begin
      realtime_sample_value <= link.wdata;
    end else if (wr && link.addr == `DEV_CTRL3) begin
      realtime_sign_format <= link.wdata[`CTRL3_FMT_BIT];
      input_source <= link.wdata[`CTRL3_SRC_BIT];
      ac_coupled_input <= link.wdata[`CTRL3_AC_BIT];
    end
  end

  // Launch bit and its sources
  always_ff @(posedge aclk) begin
    if (clr_regs) begin
      launch <= 1'b0;
    end else if (run_done) begin
      launch <= 1'b0;
    end else if (wr && link.addr == `DEV_LAUNCH) begin
      launch <= link.wdata[0];
    end else if (mode == `M_EDGE && rise) begin
      launch <= !launch;
    end else if (mode == `M_LEVEL && (rise || fall)) begin
      launch <= rise;
    end
  end

  // Run timer
  always_ff @(posedge aclk) begin
    if (clr_regs || !launch || run_done) begin
      run_cnt <= 16'h0000;
    end else begin
      run_cnt <= run_cnt + 16'h0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (clr_regs) begin
      check_outcome_flag <= 1'b0;
    end else if (run_done && checking) begin
      check_outcome_flag <= fault_lvl;
    end else if (rd && link.addr == `DEV_STATUS) begin
      check_outcome_flag <= 1'b0;
    end
  end

  // Read data selection
  always_comb begin
    next_rdata = 8'h00;
    unique case (link.addr)
      `DEV_STATUS: next_rdata[`STATUS_OUTCOME_BIT] = check_outcome_flag;
      `DEV_MODE: next_rdata = {soft_reset_bit, standby, 3'h0, mode};
      `DEV_SAMPLE: next_rdata = realtime_sample_value;
      `DEV_LAUNCH: next_rdata[0] = launch;
      `DEV_CTRL3: begin
        next_rdata[`CTRL3_FMT_BIT] = realtime_sign_format;
        next_rdata[`CTRL3_SRC_BIT] = input_source;
        next_rdata[`CTRL3_AC_BIT] = ac_coupled_input;
      end
      default: next_rdata = 8'h00;
    endcase
  end

  // Link answer one cycle after request
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link.ack <= 1'b0;
      link.rdata <= 8'h00;
    end else begin
      link.ack <= take;
      if (rd) begin
        link.rdata <= next_rdata;
      end
    end
  end

  // Actuator drive
  always_ff @(posedge aclk) begin
    if (clr_regs || standby) begin
      drive_level <= 8'h00;
      drive_active <= 1'b0;
    end else begin
      unique case (mode)
        `M_PWM_ANALOG: begin
          drive_level <= input_source ? analog_level : {8{trig_lvl}};
          drive_active <= 1'b1;
        end
        `M_AUDIO: begin
          drive_level <= analog_level;
          drive_active <= input_source && ac_coupled_input;
        end
        `M_REALTIME: begin
          drive_level <= realtime_sign_format ? realtime_sample_value
                                              : realtime_sample_value ^ `SIGN_FLIP;
          drive_active <= 1'b1;
        end
        default: begin
          drive_level <= launch ? `PLAY_LEVEL : 8'h00;
          drive_active <= launch;
        end
      endcase
    end
  end
endmodule

// ===== rtl/haptic_mode_host.sv
// Controller end: AXI4-Lite slave for software, master of the device link
// Assumes one aclk shared with the device; software sees five registers
`timescale 1ns/1ps
`include "haptic_consts.svh"
module haptic_mode_host (
  input wire logic aclk,
  input wire logic aresetn,
  haptic_link.host link,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq
);
  haptic_pkg::link_state_e state;
  logic [31:0] aw_q;
  logic [31:0] w_q;
  logic do_write;
  logic cmd_go;
  logic [7:0] last_rdata;
  logic [`IRQ_W-1:0] irq_status;
  logic [`IRQ_W-1:0] irq_enable;
  logic [`IRQ_W-1:0] irq_set;
  logic [`IRQ_W-1:0] irq_clr;

  assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign cmd_go = do_write && aw_q == `H_CMD;
  assign irq_set = {cmd_go && state != haptic_pkg::LINK_IDLE,
                    state == haptic_pkg::LINK_WAIT && link.ack};
  assign irq_clr = (do_write && aw_q == `H_IRQ_CLEAR) ? w_q[`IRQ_W-1:0] : '0;

  // Write address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      aw_q <= 32'h0000_0000;
      w_q <= 32'h0000_0000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= s_axi_wdata;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_q == `H_CMD || aw_q == `H_IRQ_ENABLE || aw_q == `H_IRQ_CLEAR)
                       ? `RESP_OKAY : `RESP_DECERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `RESP_OKAY;
      unique case (s_axi_araddr)
        `H_CMD: s_axi_rdata <= {15'h0000, link.we, link.wdata, link.addr};
        `H_STATUS: s_axi_rdata <= {16'h0000, last_rdata, 7'h00,
                                   state == haptic_pkg::LINK_WAIT};
        `H_IRQ_STATUS: s_axi_rdata <= {30'h0000_0000, irq_status};
        `H_IRQ_ENABLE: s_axi_rdata <= {30'h0000_0000, irq_enable};
        `H_IRQ_CLEAR: s_axi_rdata <= 32'h0000_0000;
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `RESP_DECERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Device link transfers; are software ordering duties
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= haptic_pkg::LINK_IDLE;
      link.req <= 1'b0;
      link.we <= 1'b0;
      link.addr <= 8'h00;
      link.wdata <= 8'h00;
      last_rdata <= 8'h00;
    end else begin
      unique case (state)
        haptic_pkg::LINK_IDLE: begin
          if (cmd_go) begin
            link.req <= 1'b1;
            link.we <= w_q[`H_CMD_WRITE_BIT];
            link.addr <= w_q[7:0];
            link.wdata <= w_q[15:8];
            state <= haptic_pkg::LINK_WAIT;
          end
        end
        haptic_pkg::LINK_WAIT: begin
          if (link.ack) begin
            link.req <= 1'b0;
            last_rdata <= link.rdata;
            state <= haptic_pkg::LINK_IDLE;
          end
        end
      endcase
    end
  end

  // Interrupt status, set wins over clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= '0;
      irq_enable <= '0;
      irq <= 1'b0;
    end else begin
      irq_status <= (irq_status & ~irq_clr) | irq_set;
      if (do_write && aw_q == `H_IRQ_ENABLE) begin
        irq_enable <= w_q[`IRQ_W-1:0];
      end
      irq <= |(irq_status & irq_enable);
    end
  end
endmodule

// ===== testbench/haptic_mode_properties.sv
// Checker of the device link handshake and device readback
// Assumes instantiation beside the link, signals connected by name
`timescale 1ns/1ps
`include "haptic_consts.svh"
module haptic_mode_properties (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic req,
  input wire logic we,
  input wire haptic_pkg::byte_t addr,
  input wire haptic_pkg::byte_t wdata,
  input wire logic ack,
  input wire haptic_pkg::byte_t rdata
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  ack_one_late_a: assert property (req && !ack |=> ack)
    else $error("ack not one cycle after request");
  ack_has_cause_a: assert property (ack |-> $past(req) && !$past(ack))
    else $error("ack without request");
  ack_pulse_a: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  req_held_a: assert property (req && !ack |=> req && $stable(addr) && $stable(we) && $stable(wdata))
    else $error("request changed before ack");
  req_drop_a: assert property (ack |=> !req)
    else $error("request kept after ack");
  rdata_moves_a: assert property ($changed(rdata) |-> ack && !we)
    else $error("read data changed outside a read");
  srst_clear_a: assert property (ack && !we && addr == `DEV_MODE |-> !rdata[7])
    else $error("soft reset bit read as set");
  resv_zero_a: assert property (ack && !we && addr == `DEV_MODE |-> rdata[5:3] == 3'h0)
    else $error("reserved mode bits not zero");
  unmapped_zero_a: assert property (ack && !we && addr == 8'h03 |-> rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule

// ===== testbench/haptic_mode_control_tb.sv
// Bench for the haptic mode link, software side to device pins
// Assumes the design files and constants header on the include path
`timescale 1ns/1ps
`include "haptic_consts.svh"
module haptic_mode_control_tb;
  localparam int PLAY = 40;
  localparam int CHECK = 60;
  logic aclk, aresetn, pin, flt, awv, wv, bre, arv, rre;
  logic awr, wr, bv, arr, rv, irq, da, launch;
  logic [7:0] ana, dl, b;
  logic [31:0] awa, wd, ara, rd, d;
  logic [1:0] br, rr, rs;
  int n_errors, n_tests;
  haptic_link haptic_link_inst ();
  haptic_mode_device #(.PLAY_CYCLES(PLAY), .CHECK_CYCLES(CHECK)) haptic_mode_device_inst (
    .aclk(aclk), .aresetn(aresetn), .link(haptic_link_inst), .input_trigger_pin(pin),
    .analog_level(ana), .actuator_fault(flt), .drive_level(dl), .drive_active(da),
    .launch(launch));
  haptic_mode_host haptic_mode_host_inst (
    .aclk(aclk), .aresetn(aresetn), .link(haptic_link_inst), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre), .irq(irq));
  haptic_mode_properties haptic_mode_properties_inst (
    .aclk(aclk), .aresetn(aresetn), .req(haptic_link_inst.req), .we(haptic_link_inst.we),
    .addr(haptic_link_inst.addr), .wdata(haptic_link_inst.wdata),
    .ack(haptic_link_inst.ack), .rdata(haptic_link_inst.rdata));

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic axw(input logic [31:0] a, input logic [31:0] v);
    @(posedge aclk);
    awa <= a;
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    do begin
      @(posedge aclk);
      if (awr === 1'b1) awv <= 1'b0;
      if (wr === 1'b1) wv <= 1'b0;
    end while (bv !== 1'b1);
    rs = br;
    bre <= 1'b0;
  endtask

  task automatic axr(input logic [31:0] a, output logic [31:0] v);
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    do begin
      @(posedge aclk);
      if (arr === 1'b1) arv <= 1'b0;
    end while (rv !== 1'b1);
    v = rd;
    rs = rr;
    rre <= 1'b0;
  endtask

  task automatic poll;
    logic [31:0] s;
    do begin
      axr(`H_STATUS, s);
    end while (s[0] !== 1'b0);
  endtask

  task automatic dw(input logic [7:0] a, input logic [7:0] v);
    axw(`H_CMD, {15'h0, 1'b1, v, a});
    poll();
  endtask

  task automatic dr(input logic [7:0] a, output logic [7:0] v);
    logic [31:0] s;
    axw(`H_CMD, {24'h0, a});
    poll();
    axr(`H_STATUS, s);
    v = s[15:8];
  endtask

  task automatic wl(input logic e, input int lim);
    int t;
    t = 0;
    while (launch !== e && t < lim) begin
      @(posedge aclk);
      t++;
    end
    chk("launch", e, launch);
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    give_verdict();
  end

  initial begin
    aresetn = 1'b0;
    pin = 1'b0;
    flt = 1'b0;
    ana = 8'h5A;
    {awv, wv, bre, arv, rre} = 5'h00;
    {awa, wd, ara} = 96'h0;
    n_errors = 0;
    n_tests = 0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    chk("launch0", 0, launch);
    chk("active0", 0, da);
    dr(`DEV_MODE, b);
    chk("mode_rst", 8'h40, b);
    axr(32'h0000_0020, d);
    chk("rd_decerr", `RESP_DECERR, rs);
    axw(32'h0000_0020, 32'h0);
    chk("wr_decerr", `RESP_DECERR, rs);
    axr(`H_IRQ_CLEAR, d);
    chk("clr_reads0", 0, d);
    axw(`H_IRQ_CLEAR, 32'h3);
    axw(`H_IRQ_ENABLE, 32'h1);
    chk("irq_idle", 0, irq);
    dw(`DEV_SAMPLE, 8'h10);
    chk("irq_set", 1, irq);
    axw(`H_IRQ_CLEAR, 32'h1);
    axr(`H_IRQ_STATUS, d);
    chk("irq_sts0", 0, d);
    chk("irq_clr", 0, irq);
    axw(`H_IRQ_ENABLE, 32'h0);
    dw(`DEV_SAMPLE, 8'h10);
    axr(`H_IRQ_STATUS, d);
    chk("irq_sts1", 1, d);
    chk("irq_mask", 0, irq);
    dw(`DEV_MODE, 8'h3D);
    dr(`DEV_MODE, b);
    chk("resv", 8'h05, b);
    dw(8'h03, 8'hFF);
    dr(8'h03, b);
    chk("unmapped", 0, b);
    chk("rt_signed", 8'h90, dl);
    chk("rt_active", 1, da);
    dw(`DEV_CTRL3, 8'h08);
    chk("rt_unsigned", 8'h10, dl);
    dw(`DEV_MODE, 8'h45);
    chk("stby_lvl", 0, dl);
    chk("stby_act", 0, da);
    dw(`DEV_MODE, 8'h03);
    chk("pwm_act", 1, da);
    dw(`DEV_CTRL3, 8'h22);
    dw(`DEV_MODE, 8'h04);
    chk("audio_act", 1, da);
    chk("audio_lvl", 8'h5A, dl);
    dw(`DEV_MODE, 8'h03);
    chk("analog_lvl", 8'h5A, dl);
    dw(`DEV_MODE, 8'h00);
    pin <= 1'b1;
    repeat (8) @(posedge aclk);
    chk("pin_ignored", 0, launch);
    pin <= 1'b0;
    dw(`DEV_LAUNCH, 8'h01);
    chk("sw_go", 1, launch);
    chk("play_lvl", `PLAY_LEVEL, dl);
    wl(1'b0, PLAY + 10);
    dw(`DEV_MODE, 8'h01);
    pin <= 1'b1;
    wl(1'b1, 10);
    pin <= 1'b0;
    repeat (6) @(posedge aclk);
    pin <= 1'b1;
    wl(1'b0, 10);
    pin <= 1'b0;
    dw(`DEV_MODE, 8'h02);
    pin <= 1'b1;
    wl(1'b1, 10);
    pin <= 1'b0;
    wl(1'b0, 10);
    dw(`DEV_LAUNCH, 8'h01);
    pin <= 1'b1;
    repeat (8) @(posedge aclk);
    chk("lvl_same", 1, launch);
    pin <= 1'b0;
    wl(1'b0, 10);
    for (int m = 6; m < 8; m++) begin
      flt <= (m == 6);
      dw(`DEV_MODE, 8'(m));
      dw(`DEV_LAUNCH, 8'h01);
      chk("chk_go", 1, launch);
      wl(1'b0, CHECK + 10);
      dr(`DEV_STATUS, b);
      chk("outcome", m == 6, b[3]);
      dr(`DEV_STATUS, b);
      chk("outcome_rd", 0, b[3]);
    end
    dw(`DEV_MODE, 8'h00);
    dw(`DEV_SAMPLE, 8'h33);
    dw(`DEV_LAUNCH, 8'h01);
    dw(`DEV_MODE, 8'h80);
    chk("abort", 0, launch);
    chk("abort_act", 0, da);
    dr(`DEV_MODE, b);
    chk("srst_mode", 8'h40, b);
    dr(`DEV_SAMPLE, b);
    chk("srst_smp", 0, b);
    dr(`DEV_CTRL3, b);
    chk("srst_ctl", 0, b);
    give_verdict();
  end
endmodule
